// ### tmr8_pkg.sv
// Shared constants and types of the 8-bit timer/counter with compare unit.
package tmr8_pkg;

  // ----------------------------------------
  // Counter extremes
  // ----------------------------------------
  localparam logic [7:0] TMR8_BOTTOM = 8'h00;
  localparam logic [7:0] TMR8_MAX    = 8'hff;

  // ----------------------------------------
  // Waveform modes
  // ----------------------------------------
  typedef enum logic [1:0] {
    TMR8_WGM_NORMAL = 2'b00,
    TMR8_WGM_PHASE  = 2'b01,
    TMR8_WGM_CTC    = 2'b10,
    TMR8_WGM_FAST   = 2'b11
  } tmr8_wgm_type;

  // ----------------------------------------
  // Compare output modes
  // ----------------------------------------
  localparam logic [1:0] TMR8_COM_OFF    = 2'h0;
  localparam logic [1:0] TMR8_COM_TOGGLE = 2'h1;
  localparam logic [1:0] TMR8_COM_CLEAR  = 2'h2;
  localparam logic [1:0] TMR8_COM_SET    = 2'h3;

  // ----------------------------------------
  // Clock select codes
  // ----------------------------------------
  localparam logic [2:0] TMR8_CS_STOP   = 3'h0;
  localparam logic [2:0] TMR8_CS_DIRECT = 3'h1;

  // ----------------------------------------
  // Flag and mask bit positions
  // ----------------------------------------
  localparam int TMR8_BIT_OVF = 0;
  localparam int TMR8_BIT_CMP = 1;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] TMR8_RST_COUNT   = 8'h00;
  localparam logic [7:0] TMR8_RST_COMPARE = 8'h00;
  localparam logic [1:0] TMR8_RST_FLAGS   = 2'h0;

endpackage

// ### tmr8_counter_compare.sv
// Top module of the 8-bit timer/counter with one output compare channel.
`timescale 1ns/1ns

// Summary of operation
// - Counter and compare value are 8-bit, CPU readable and writable.
// - Interrupt requests show as flags and are gated by individual mask bits.
// - Tick comes from I/O clock or prescaler, or from oscillator when async set.
// - Clock select zero stops the counter: no count, clear or flag action.
// - CPU may read and write the counter at any time.
// - A CPU counter write wins over clear, increment or decrement.
// - Bottom is 0x00, max is 0xFF, top is 0xFF or compare value per mode.
// - Each tick clears, increments or decrements the counter as mode dictates.
// - Waveform mode bits set the count sequence and overflow flag timing.
// - Comparator flags equality; compare flag sets on the following tick.
// - Compare flag requests interrupt when enabled; clears on ack or write one.
// - Waveform output follows match, mode bits, output mode, max and bottom.
// - PWM modes double buffer compare value, updated at max (0xFF) only.
// - CPU compare access reaches buffer when buffered, else active register.
// - Force strobe in non-PWM modes acts on output only, no flag or clear.
// - A counter write blocks compare matches in the next tick, even stopped.
// - Normal mode wraps past 0xFF; overflow flag sets as counter becomes zero.
// - Mode 2 clears counter on compare match, so compare value is top.
module tmr8_counter_compare
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  // Configuration bits
  input  wire logic       async_clock_select,
  input  wire logic [2:0] clock_select_field,
  input  wire logic [1:0] waveform_mode_bits,
  input  wire logic [1:0] compare_output_mode,
  input  wire logic [1:0] timer_mask_reg,
  // Tick sources
  input  wire logic       prescaled_tick,
  input  wire logic       osc_pin_a,
  // CPU access
  input  wire logic       count_wr,
  input  wire logic [7:0] count_wdata,
  input  wire logic       compare_wr,
  input  wire logic [7:0] compare_wdata,
  input  wire logic       flag_wr,
  input  wire logic [1:0] flag_wdata,
  input  wire logic [1:0] irq_ack,
  input  wire logic       force_compare_strobe,
  // Status and outputs
  output logic      [7:0] count_value,
  output logic      [7:0] compare_value,
  output logic      [1:0] timer_flag_reg,
  output logic            overflow_irq,
  output logic            compare_irq,
  output logic            compare_output
);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rst_meta_r;
  logic rst_n_r;

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // Applies an output mode action to the current output level.
  function automatic logic com_action(input logic [1:0] com, input logic cur);
    logic res;
    res = cur;
    if (com == tmr8_pkg::TMR8_COM_TOGGLE)
      res = ~cur;
    else if (com == tmr8_pkg::TMR8_COM_CLEAR)
      res = 1'b0;
    else if (com == tmr8_pkg::TMR8_COM_SET)
      res = 1'b1;
    return res;
  endfunction

  // True for the two pulse width modes.
  function automatic logic is_pwm(input logic [1:0] wgm);
    return (wgm == tmr8_pkg::TMR8_WGM_PHASE) || (wgm == tmr8_pkg::TMR8_WGM_FAST);
  endfunction

  // ----------------------------------------
  // Tick selection
  // ----------------------------------------
  logic osc_prev_r;
  logic tick;

  always_ff @(posedge sys_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
      osc_prev_r <= 1'b0;
    else
      osc_prev_r <= osc_pin_a;
  end

  always_comb
  begin
    tick = 1'b0;
    if (clock_select_field == tmr8_pkg::TMR8_CS_STOP)
      tick = 1'b0;
    else if (async_clock_select)
      tick = osc_pin_a & ~osc_prev_r;
    else if (clock_select_field == tmr8_pkg::TMR8_CS_DIRECT)
      tick = 1'b1;
    else
      tick = prescaled_tick;
  end

  // ----------------------------------------
  // Mode decode and extremes
  // ----------------------------------------
  tmr8_pkg::tmr8_wgm_type wgm;
  logic [7:0] count_r;
  logic [7:0] ocr_active_r;
  logic [7:0] ocr_buf_r;
  logic       dir_down_r;
  logic       at_bottom;
  logic       at_max;
  logic       at_top;
  logic       match;
  logic       pwm;

  assign wgm = tmr8_pkg::tmr8_wgm_type'(waveform_mode_bits);
  assign pwm = is_pwm(waveform_mode_bits);

  assign at_bottom = (count_r == tmr8_pkg::TMR8_BOTTOM);
  assign at_max    = (count_r == tmr8_pkg::TMR8_MAX);
  assign at_top    = (wgm == tmr8_pkg::TMR8_WGM_CTC) ? (count_r == ocr_active_r) : at_max;

  assign match = (count_r == ocr_active_r);

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  logic [7:0] count_nxt;

  always_comb
  begin
    count_nxt = count_r;
    case (wgm)
      tmr8_pkg::TMR8_WGM_NORMAL: count_nxt = count_r + 8'h01;
      tmr8_pkg::TMR8_WGM_CTC:    count_nxt = at_top ? tmr8_pkg::TMR8_BOTTOM : count_r + 8'h01;
      tmr8_pkg::TMR8_WGM_FAST:   count_nxt = count_r + 8'h01;
      tmr8_pkg::TMR8_WGM_PHASE:
      begin
        if (dir_down_r)
          count_nxt = at_bottom ? count_r + 8'h01 : count_r - 8'h01;
        else
          count_nxt = at_max ? count_r - 8'h01 : count_r + 8'h01;
      end
      default: count_nxt = count_r;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
      count_r <= tmr8_pkg::TMR8_RST_COUNT;
    else if (count_wr)
      count_r <= count_wdata;
    else if (tick)
      count_r <= count_nxt;
  end

  // Phase correct direction turns at max and bottom.
  always_ff @(posedge sys_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
      dir_down_r <= 1'b0;
    else if (wgm != tmr8_pkg::TMR8_WGM_PHASE)
      dir_down_r <= 1'b0;
    else if (tick && !count_wr && at_max)
      dir_down_r <= 1'b1;
    else if (tick && !count_wr && at_bottom)
      dir_down_r <= 1'b0;
  end

  // ----------------------------------------
  // Compare match blocking
  // ----------------------------------------
  logic block_r;
  logic match_evt;

  always_ff @(posedge sys_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
      block_r <= 1'b0;
    else if (count_wr)
      block_r <= 1'b1;
    else if (tick)
      block_r <= 1'b0;
  end

  assign match_evt = tick && match && !block_r && !count_wr;

  // ----------------------------------------
  // Compare value buffering
  // ----------------------------------------
  logic buf_load;

  assign buf_load = pwm && tick && !count_wr && at_max;

  always_ff @(posedge sys_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
      ocr_buf_r <= tmr8_pkg::TMR8_RST_COMPARE;
    else if (compare_wr)
      ocr_buf_r <= compare_wdata;
  end

  always_ff @(posedge sys_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
      ocr_active_r <= tmr8_pkg::TMR8_RST_COMPARE;
    else if (!pwm && compare_wr)
      ocr_active_r <= compare_wdata;
    else if (!pwm)
      ocr_active_r <= ocr_buf_r;
    else if (buf_load)
      ocr_active_r <= ocr_buf_r;
  end

  // ----------------------------------------
  // Flags and interrupt requests
  // ----------------------------------------
  logic [1:0] flag_r;
  logic [1:0] flag_set;
  logic [1:0] flag_clr;
  logic       ovf_evt;

  always_comb
  begin
    ovf_evt = 1'b0;
    if (tick && !count_wr)
    begin
      if (wgm == tmr8_pkg::TMR8_WGM_PHASE)
        ovf_evt = at_bottom && dir_down_r;
      else
        ovf_evt = at_max;
    end
  end

  always_comb
  begin
    flag_set = 2'h0;
    flag_set[tmr8_pkg::TMR8_BIT_OVF] = ovf_evt;
    flag_set[tmr8_pkg::TMR8_BIT_CMP] = match_evt;
    flag_clr = irq_ack | (flag_wr ? flag_wdata : 2'h0);
  end

  always_ff @(posedge sys_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
      flag_r <= tmr8_pkg::TMR8_RST_FLAGS;
    else
      flag_r <= (flag_r & ~flag_clr) | flag_set;
  end

  always_ff @(posedge sys_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      overflow_irq <= 1'b0;
      compare_irq  <= 1'b0;
    end
    else
    begin
      overflow_irq <= flag_r[tmr8_pkg::TMR8_BIT_OVF] & timer_mask_reg[tmr8_pkg::TMR8_BIT_OVF];
      compare_irq  <= flag_r[tmr8_pkg::TMR8_BIT_CMP] & timer_mask_reg[tmr8_pkg::TMR8_BIT_CMP];
    end
  end

  // ----------------------------------------
  // Waveform generator
  // ----------------------------------------
  logic oc_nxt;
  logic force_evt;

  assign force_evt = force_compare_strobe && !pwm;

  always_comb
  begin
    oc_nxt = compare_output;
    case (wgm)
      tmr8_pkg::TMR8_WGM_NORMAL, tmr8_pkg::TMR8_WGM_CTC:
      begin
        if (match_evt || force_evt)
          oc_nxt = com_action(compare_output_mode, compare_output);
      end
      tmr8_pkg::TMR8_WGM_FAST:
      begin
        if (compare_output_mode[1] && match_evt)
          oc_nxt = compare_output_mode[0];
        if (compare_output_mode[1] && tick && !count_wr && at_max)
          oc_nxt = ~compare_output_mode[0];
      end
      tmr8_pkg::TMR8_WGM_PHASE:
      begin
        if (compare_output_mode[1] && match_evt)
          oc_nxt = dir_down_r ^ compare_output_mode[0];
      end
      default: oc_nxt = compare_output;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
      compare_output <= 1'b0;
    else
      compare_output <= oc_nxt;
  end

  // ----------------------------------------
  // Visible registers
  // ----------------------------------------
  // CPU readback copies
  always_ff @(posedge sys_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      count_value    <= tmr8_pkg::TMR8_RST_COUNT;
      compare_value  <= tmr8_pkg::TMR8_RST_COMPARE;
      timer_flag_reg <= tmr8_pkg::TMR8_RST_FLAGS;
    end
    else
    begin
      count_value    <= count_r;
      compare_value  <= ocr_buf_r;
      timer_flag_reg <= flag_r;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  // Stopped counter holds
  AST_STOPPED_HOLDS: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
    (clock_select_field == tmr8_pkg::TMR8_CS_STOP) && !count_wr |=> $stable(count_r))
    else $error("Counter moved while stopped");

  AST_WRITE_WINS: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
    count_wr |=> ##1 (count_value == $past(count_wdata, 2)))
    else $error("Counter write lost");

  AST_NORMAL_WRAP: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
    tick && !count_wr && at_max && (wgm == tmr8_pkg::TMR8_WGM_NORMAL)
    |=> (count_r == 8'h00) && flag_r[tmr8_pkg::TMR8_BIT_OVF])
    else $error("Normal wrap wrong");

  AST_CTC_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
    tick && !count_wr && match && (wgm == tmr8_pkg::TMR8_WGM_CTC) |=> count_r == 8'h00)
    else $error("Match clear missing");

  AST_MATCH_FLAG: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
    tick && match && !block_r && !count_wr |=> flag_r[tmr8_pkg::TMR8_BIT_CMP])
    else $error("Compare flag not set");

  AST_BLOCKED: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
    count_wr ##1 (tick && !count_wr && !flag_r[tmr8_pkg::TMR8_BIT_CMP])
    |=> !flag_r[tmr8_pkg::TMR8_BIT_CMP])
    else $error("Match not blocked");

  AST_FORCE: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
    force_compare_strobe && !pwm && (compare_output_mode == tmr8_pkg::TMR8_COM_TOGGLE)
    |=> compare_output != $past(compare_output))
    else $error("Force had no effect");

  AST_CMP_IRQ: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
    flag_r[tmr8_pkg::TMR8_BIT_CMP] && timer_mask_reg[tmr8_pkg::TMR8_BIT_CMP] |=> compare_irq)
    else $error("Compare request missing");

  // Buffered write stays out of active register
  AST_BUFFERED: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
    pwm && !buf_load |=> $stable(ocr_active_r))
    else $error("Active compare changed off top");

endmodule

// ### test_tmr8_counter_compare.sv
// Self-checking testbench of the 8-bit timer/counter with compare unit.
`timescale 1ns/1ns

module test_tmr8_counter_compare;

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic       sys_clk;
  logic       resetn;
  logic       async_clock_select;
  logic [2:0] clock_select_field;
  logic [1:0] waveform_mode_bits;
  logic [1:0] compare_output_mode;
  logic [1:0] timer_mask_reg;
  logic       prescaled_tick;
  logic       osc_pin_a;
  logic       count_wr;
  logic [7:0] count_wdata;
  logic       compare_wr;
  logic [7:0] compare_wdata;
  logic       flag_wr;
  logic [1:0] flag_wdata;
  logic [1:0] irq_ack;
  logic       force_compare_strobe;
  logic [7:0] count_value;
  logic [7:0] compare_value;
  logic [1:0] timer_flag_reg;
  logic       overflow_irq;
  logic       compare_irq;
  logic       compare_output;
  int         err_count;
  int         checked;
  logic [1:0] com_tab [5];
  logic       out_tab [5];

  tmr8_counter_compare tmr8_counter_compare_inst
  (
    .sys_clk              (sys_clk),
    .resetn               (resetn),
    .async_clock_select   (async_clock_select),
    .clock_select_field   (clock_select_field),
    .waveform_mode_bits   (waveform_mode_bits),
    .compare_output_mode  (compare_output_mode),
    .timer_mask_reg       (timer_mask_reg),
    .prescaled_tick       (prescaled_tick),
    .osc_pin_a            (osc_pin_a),
    .count_wr             (count_wr),
    .count_wdata          (count_wdata),
    .compare_wr           (compare_wr),
    .compare_wdata        (compare_wdata),
    .flag_wr              (flag_wr),
    .flag_wdata           (flag_wdata),
    .irq_ack              (irq_ack),
    .force_compare_strobe (force_compare_strobe),
    .count_value          (count_value),
    .compare_value        (compare_value),
    .timer_flag_reg       (timer_flag_reg),
    .overflow_irq         (overflow_irq),
    .compare_irq          (compare_irq),
    .compare_output       (compare_output)
  );

  // ----------------------------------------
  // Clock and watchdog
  // ----------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  initial
  begin
    repeat (5000) @(posedge sys_clk);
    err_count = err_count + 1;
    $display("wrong value at %0t: run did not finish in time", $time);
    conclude();
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked = checked + 1;
    if (got !== exp)
    begin
      err_count = err_count + 1;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic tick();
    prescaled_tick = 1'b1;
    cycles(1);
    prescaled_tick = 1'b0;
    cycles(1);
  endtask

  task automatic wcount(input logic [7:0] v);
    count_wr    = 1'b1;
    count_wdata = v;
    cycles(1);
    count_wr = 1'b0;
    cycles(1);
  endtask

  task automatic wcmp(input logic [7:0] v);
    compare_wr    = 1'b1;
    compare_wdata = v;
    cycles(1);
    compare_wr = 1'b0;
    cycles(1);
  endtask

  task automatic wflag(input logic [1:0] v);
    flag_wr    = 1'b1;
    flag_wdata = v;
    cycles(1);
    flag_wr = 1'b0;
    cycles(1);
  endtask

  task automatic conclude();
    if (err_count == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    err_count = 0;
    checked = 0;
    com_tab = '{tmr8_pkg::TMR8_COM_SET, tmr8_pkg::TMR8_COM_CLEAR, tmr8_pkg::TMR8_COM_TOGGLE,
                tmr8_pkg::TMR8_COM_TOGGLE, tmr8_pkg::TMR8_COM_OFF};
    out_tab = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    resetn = 1'b0;
    async_clock_select = 1'b0;
    clock_select_field = tmr8_pkg::TMR8_CS_STOP;
    waveform_mode_bits = tmr8_pkg::TMR8_WGM_NORMAL;
    compare_output_mode = tmr8_pkg::TMR8_COM_OFF;
    timer_mask_reg = 2'h0;
    prescaled_tick = 1'b0;
    osc_pin_a = 1'b0;
    count_wr = 1'b0;
    count_wdata = 8'h00;
    compare_wr = 1'b0;
    compare_wdata = 8'h00;
    flag_wr = 1'b0;
    flag_wdata = 2'h0;
    irq_ack = 2'h0;
    force_compare_strobe = 1'b0;
    cycles(10);
    resetn = 1'b1;
    cycles(3);
    chk(count_value, tmr8_pkg::TMR8_RST_COUNT, "reset count");
    chk(compare_value, tmr8_pkg::TMR8_RST_COMPARE, "reset compare");
    chk({6'h0, timer_flag_reg}, 8'h00, "reset flags");
    chk({7'h0, compare_output}, 8'h00, "reset output");
    wcount(8'h10);
    repeat (3) tick();
    cycles(3);
    chk(count_value, 8'h10, "stopped count");
    chk({6'h0, timer_flag_reg}, 8'h00, "stopped flags");
    // Write wins over a coincident tick.
    clock_select_field = 3'h2;
    prescaled_tick = 1'b1;
    count_wr = 1'b1;
    count_wdata = 8'h40;
    cycles(1);
    prescaled_tick = 1'b0;
    count_wr = 1'b0;
    cycles(3);
    chk(count_value, 8'h40, "write priority");
    // Wrap past max with overflow flag.
    wcount(8'hfe);
    tick();
    tick();
    cycles(3);
    chk(count_value, tmr8_pkg::TMR8_BOTTOM, "wrap count");
    chk({7'h0, timer_flag_reg[0]}, 8'h01, "overflow flag");
    chk({7'h0, overflow_irq}, 8'h00, "masked overflow");
    timer_mask_reg = 2'h1;
    cycles(3);
    chk({7'h0, overflow_irq}, 8'h01, "unmasked overflow");
    wflag(2'h3);
    cycles(3);
    chk({7'h0, overflow_irq}, 8'h00, "overflow cleared");
    // Counter write blocks the match on the very next tick.
    wcmp(8'h05);
    count_wr = 1'b1;
    count_wdata = 8'h05;
    cycles(1);
    count_wr = 1'b0;
    prescaled_tick = 1'b1;
    cycles(1);
    prescaled_tick = 1'b0;
    cycles(3);
    chk({6'h0, timer_flag_reg}, 8'h00, "blocked match");
    chk(compare_value, 8'h05, "compare readback");
    wcount(8'h04);
    tick();
    tick();
    cycles(3);
    chk({6'h0, timer_flag_reg}, 8'h02, "compare flag");
    // Force strobe acts on output only.
    clock_select_field = tmr8_pkg::TMR8_CS_STOP;
    wflag(2'h3);
    for (int i = 0; i < 5; i++)
    begin
      compare_output_mode = com_tab[i];
      force_compare_strobe = 1'b1;
      cycles(1);
      force_compare_strobe = 1'b0;
      cycles(3);
      chk({7'h0, compare_output}, {7'h0, out_tab[i]}, "forced output");
    end
    chk({6'h0, timer_flag_reg}, 8'h00, "force flags");
    chk(count_value, 8'h06, "force count");
    compare_output_mode = tmr8_pkg::TMR8_COM_OFF;
    clock_select_field = 3'h2;
    waveform_mode_bits = tmr8_pkg::TMR8_WGM_CTC;
    timer_mask_reg = 2'h2;
    wcmp(8'h03);
    wcount(8'h02);
    wflag(2'h3);
    tick();
    tick();
    cycles(3);
    chk(count_value, 8'h00, "ctc clear");
    chk({6'h0, timer_flag_reg}, 8'h02, "ctc flag");
    chk({7'h0, compare_irq}, 8'h01, "compare request");
    irq_ack = 2'h2;
    cycles(1);
    irq_ack = 2'h0;
    cycles(3);
    chk({6'h0, timer_flag_reg}, 8'h00, "ack clears flag");
    // Buffered compare in fast mode loads only at max.
    waveform_mode_bits = tmr8_pkg::TMR8_WGM_FAST;
    wcmp(8'h12);
    cycles(3);
    chk(compare_value, 8'h12, "buffer readback");
    wcount(8'h10);
    repeat (3) tick();
    cycles(3);
    chk({6'h0, timer_flag_reg}, 8'h00, "buffer not active");
    wcount(8'hfe);
    tick();
    tick();
    wcount(8'h11);
    wflag(2'h3);
    tick();
    tick();
    cycles(3);
    chk({6'h0, timer_flag_reg}, 8'h02, "buffer loaded");
    waveform_mode_bits = tmr8_pkg::TMR8_WGM_NORMAL;
    async_clock_select = 1'b1;
    wcount(8'h20);
    repeat (3)
    begin
      osc_pin_a = 1'b1;
      cycles(4);
      osc_pin_a = 1'b0;
      cycles(4);
    end
    cycles(3);
    chk(count_value, 8'h23, "oscillator ticks");
    // Phase correct mode turns at max and overflows at bottom.
    async_clock_select = 1'b0;
    clock_select_field = tmr8_pkg::TMR8_CS_STOP;
    waveform_mode_bits = tmr8_pkg::TMR8_WGM_PHASE;
    compare_output_mode = tmr8_pkg::TMR8_COM_CLEAR;
    wcmp(8'hfe);
    wcount(8'hfd);
    wflag(2'h3);
    clock_select_field = tmr8_pkg::TMR8_CS_DIRECT;
    cycles(4);
    clock_select_field = tmr8_pkg::TMR8_CS_STOP;
    cycles(3);
    chk(count_value, 8'hfd, "phase down count");
    chk(compare_value, 8'hfe, "phase buffer readback");
    chk({6'h0, timer_flag_reg}, 8'h02, "phase match flag");
    chk({7'h0, compare_output}, 8'h01, "phase output");
    wcount(8'h02);
    wflag(2'h3);
    clock_select_field = tmr8_pkg::TMR8_CS_DIRECT;
    cycles(3);
    clock_select_field = tmr8_pkg::TMR8_CS_STOP;
    cycles(3);
    chk(count_value, 8'h01, "phase bottom turn");
    chk({6'h0, timer_flag_reg}, 8'h01, "phase overflow");
    chk({7'h0, compare_output}, 8'h01, "phase output held");
    conclude();
  end

endmodule
